// ==== hw/ssdc_cfg.svh ====
// constants of the synthesizer serial divider configuration block
// assumes a 32-bit axi4-lite slave port and byte addresses below 0x10
`ifndef SSDC_CFG_SVH
`define SSDC_CFG_SVH

// register byte offsets
`define SSDC_REG_CTRL 4'h0
`define SSDC_REG_STATUS 4'h4
`define SSDC_REG_SHIFT 4'h8

// control register fields and reset value
`define SSDC_CTRL_SOFT_RST 0
`define SSDC_CTRL_OUT_GATE 1
`define SSDC_CTRL_RESET 2'h2

// axi responses
`define SSDC_RESP_OKAY 2'h0
`define SSDC_RESP_SLVERR 2'h2

// power-up settings of the serial word
`define SSDC_DEF_TEST 2'h1
`define SSDC_DEF_OUT_DIV 3'h1
`define SSDC_DEF_FB_DIV 9'h0c0
`define SSDC_DEF_SPREAD 1'h0

// fixed reference prescale ahead of the phase comparison
`define SSDC_REF_PRESCALE 16

// synchroniser reset levels: mr, oe, load, data, clock (pull levels)
`define SSDC_PIN_RESET 5'h0b
`define SSDC_PIN_SCLK 0
`define SSDC_PIN_SDATA 1
`define SSDC_PIN_SLOAD 2
`define SSDC_PIN_OE 3
`define SSDC_PIN_MR 4

`endif

// ==== hw/ssdc_pkg.sv ====
// types of the synthesizer serial divider configuration block
// assumes ssdc_cfg.svh holds all numeric constants
package ssdc_pkg;
	// serial word, first shifted bit at the top
	typedef struct packed {
		logic [1:0] test;
		logic [2:0] out_div;
		logic [8:0] fb_div;
		logic spread;
	} ssdc_word_t;

	// monitor output selection
	typedef enum logic [1:0] {
		SSDC_TST_LOW = 2'b00,
		SSDC_TST_SDATA = 2'b01,
		SSDC_TST_FB = 2'b10,
		SSDC_TST_FOUT = 2'b11
	} ssdc_test_t;
endpackage

// ==== hw/ssdc_div_if.sv ====
// control and output of one half-period divider
// assumes both ends sit on core_clk
`timescale 1ns/1ps
interface ssdc_div_if #(parameter int W = 9);
	logic tick;
	logic clr;
	logic [W-1:0] half;
	logic clk_out;
	modport ctl (output tick, output clr, output half, input clk_out);
	modport div (input tick, input clr, input half, output clk_out);
endinterface

// ==== hw/ssdc_half_div.sv ====
// half-period divider: output toggles every 'half' ticks, so duty is 50%
// assumes tick is a one-cycle enable on core_clk
`timescale 1ns/1ps
module ssdc_half_div #(
	parameter int W = 9
) (
	input wire logic core_clk,
	input wire logic rstn,
	ssdc_div_if.div dv
);
	logic [W-1:0] cnt_q, cnt_d;
	logic out_q, out_d;

	// count ticks; >= guards against a half value shrinking under the count
	always_comb begin
		cnt_d = cnt_q;
		out_d = out_q;
		if (dv.clr) begin
			cnt_d = '0;
			out_d = 1'b0;
		end else if (dv.tick) begin
			if (cnt_q >= dv.half - 1'b1) begin
				cnt_d = '0;
				out_d = ~out_q;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
			out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign dv.clk_out = out_q;

	a_half_toggle: assert property (@(posedge core_clk) disable iff (!rstn)
		dv.tick && !dv.clr && cnt_q == dv.half - 1'b1 |=> dv.clk_out != $past(dv.clk_out))
		else $error("divider missed its toggle");
	a_half_clear: assert property (@(posedge core_clk) disable iff (!rstn)
		dv.clr |=> !dv.clk_out && cnt_q == '0)
		else $error("divider not cleared");
endmodule

// ==== hw/ssdc_top.sv ====
// serial configuration of the synthesizer dividers with axi4-lite access
// assumes the serial pins, oe and master reset are asynchronous to core_clk
// and that vco_tick is a one-cycle enable from the loop model on core_clk
`timescale 1ns/1ps
`include "ssdc_cfg.svh"

module ssdc_top #(
	parameter int PAIRS = 6,
	parameter int DIV_W = 9
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic serial_load,
	input wire logic output_enable,
	input wire logic master_divider_reset,
	input wire logic vco_tick,
	output logic ref_cmp_clk,
	output logic fb_cmp_clk,
	output logic [PAIRS-1:0] fout,
	output logic [PAIRS-1:0] fout_n,
	output logic test_out,
	output ssdc_pkg::ssdc_word_t active_word,
	output logic spread_enable
);
	import ssdc_pkg::*;

	localparam int REF_HALF = `SSDC_REF_PRESCALE / 2;
	localparam ssdc_word_t WORD_RESET = '{test: `SSDC_DEF_TEST, out_div: `SSDC_DEF_OUT_DIV,
		fb_div: `SSDC_DEF_FB_DIV, spread: `SSDC_DEF_SPREAD};

	// output ratios up to 16 and the 9-bit feedback field must fit the counters
	generate
		if (PAIRS < 1 || DIV_W < 9) begin : g_bad_param
			$error("ssdc_top: PAIRS must be >= 1 and DIV_W >= 9");
		end
	endgenerate

	// two-flop synchronisers for every pin; the first stage feeds only the second
	logic [4:0] sync1_q, sync2_q;
	logic [1:0] prev_q;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= `SSDC_PIN_RESET;
			sync2_q <= `SSDC_PIN_RESET;
			prev_q <= 2'h1;
		end else begin
			sync1_q <= {master_divider_reset, output_enable, serial_load, serial_data,
				serial_clock};
			sync2_q <= sync1_q;
			prev_q <= {sync2_q[`SSDC_PIN_SLOAD], sync2_q[`SSDC_PIN_SCLK]};
		end
	end

	logic sclk_rise, load_s, load_rise, load_fall, data_s, oe_s, mr_s;
	assign data_s = sync2_q[`SSDC_PIN_SDATA];
	assign load_s = sync2_q[`SSDC_PIN_SLOAD];
	assign oe_s = sync2_q[`SSDC_PIN_OE];
	assign mr_s = sync2_q[`SSDC_PIN_MR];
	assign sclk_rise = sync2_q[`SSDC_PIN_SCLK] & ~prev_q[0];
	assign load_rise = load_s & ~prev_q[1];
	assign load_fall = ~load_s & prev_q[1];

	// shift register and active settings
	// all pins share one synchroniser depth, so their relative timing is kept
	ssdc_word_t shift_q, shift_d, cfg_q, cfg_d, shifted;
	assign shifted = ssdc_word_t'({shift_q[13:0], data_s});

	always_comb begin
		shift_d = shift_q;
		cfg_d = cfg_q;
		if (sclk_rise) begin
			shift_d = shifted;
		end
		if (load_rise) begin
			cfg_d = shift_q;
		end else if (load_fall) begin
			cfg_d.fb_div = shift_q.fb_div;
			cfg_d.out_div = shift_q.out_div;
		end else if (load_s && sclk_rise) begin
			cfg_d.fb_div = shifted.fb_div;
			cfg_d.out_div = shifted.out_div;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			shift_q <= '0;
			cfg_q <= WORD_RESET;
		end else begin
			shift_q <= shift_d;
			cfg_q <= cfg_d;
		end
	end

	assign active_word = cfg_q;
	assign spread_enable = cfg_q.spread;

	// axi4-lite slave: address and data taken in either order, one write at a time
	logic [1:0] ctrl_q, ctrl_d;
	logic [3:0] awaddr_q, awaddr_d;
	logic aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_q, bvalid_d;
	logic [7:0] wbyte_q, wbyte_d;
	logic wstrb0_q, wstrb0_d;
	logic [1:0] bresp_q, bresp_d;

	assign s_axi_awready = ~aw_full_q & ~bvalid_q;
	assign s_axi_wready = ~w_full_q & ~bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always_comb begin
		ctrl_d = ctrl_q;
		awaddr_d = awaddr_q;
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		wbyte_d = wbyte_q;
		wstrb0_d = wstrb0_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			awaddr_d = s_axi_awaddr;
			aw_full_d = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wbyte_d = s_axi_wdata[7:0];
			wstrb0_d = s_axi_wstrb[0];
			w_full_d = 1'b1;
		end
		if (aw_full_q && w_full_q) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `SSDC_RESP_OKAY;
			if ({awaddr_q[3:2], 2'b00} == `SSDC_REG_CTRL) begin
				if (wstrb0_q) begin
					ctrl_d = wbyte_q[1:0];
				end
			end else if ({awaddr_q[3:2], 2'b00} != `SSDC_REG_STATUS &&
				{awaddr_q[3:2], 2'b00} != `SSDC_REG_SHIFT) begin
				bresp_d = `SSDC_RESP_SLVERR;
			end
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= `SSDC_CTRL_RESET;
			awaddr_q <= 4'h0;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			wbyte_q <= 8'h00;
			wstrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `SSDC_RESP_OKAY;
		end else begin
			ctrl_q <= ctrl_d;
			awaddr_q <= awaddr_d;
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			wbyte_q <= wbyte_d;
			wstrb0_q <= wstrb0_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	// read channel: data captured at the address handshake, answered next cycle
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic rvalid_q, rvalid_d;

	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_comb begin
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		rvalid_d = rvalid_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = `SSDC_RESP_OKAY;
			unique case ({s_axi_araddr[3:2], 2'b00})
				`SSDC_REG_CTRL: rdata_d = {30'h0000_0000, ctrl_q};
				`SSDC_REG_STATUS: rdata_d = {17'h0_0000, cfg_q};
				`SSDC_REG_SHIFT: rdata_d = {17'h0_0000, shift_q};
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = `SSDC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 32'h0000_0000;
			rresp_q <= `SSDC_RESP_OKAY;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			rvalid_q <= rvalid_d;
		end
	end

	// dividers: reference prescale, feedback and output, all 50% duty
	logic div_clr;
	logic [DIV_W-1:0] out_half;
	assign div_clr = mr_s | ctrl_q[`SSDC_CTRL_SOFT_RST];

	// codes above 4 are not defined, they fall back to the slowest ratio
	always_comb begin
		unique case (cfg_q.out_div)
			3'h0: out_half = DIV_W'(1);
			3'h1: out_half = DIV_W'(2);
			3'h2: out_half = DIV_W'(4);
			3'h3: out_half = DIV_W'(8);
			default: out_half = DIV_W'(16);
		endcase
	end

	ssdc_div_if #(.W(DIV_W)) ref_if();
	ssdc_div_if #(.W(DIV_W)) fb_if();
	ssdc_div_if #(.W(DIV_W)) out_if();

	assign ref_if.tick = 1'b1;
	assign ref_if.clr = div_clr;
	assign ref_if.half = DIV_W'(REF_HALF);
	assign fb_if.tick = vco_tick;
	assign fb_if.clr = div_clr;
	assign fb_if.half = DIV_W'(cfg_q.fb_div);
	assign out_if.tick = vco_tick;
	assign out_if.clr = div_clr;
	assign out_if.half = out_half;

	ssdc_half_div #(.W(DIV_W)) u_ref_div (.core_clk(core_clk), .rstn(rstn), .dv(ref_if));
	ssdc_half_div #(.W(DIV_W)) u_fb_div (.core_clk(core_clk), .rstn(rstn), .dv(fb_if));
	ssdc_half_div #(.W(DIV_W)) u_out_div (.core_clk(core_clk), .rstn(rstn), .dv(out_if));

	assign ref_cmp_clk = ref_if.clk_out;
	assign fb_cmp_clk = fb_if.clk_out;

	// output pairs and monitor are registered so they never glitch
	logic [PAIRS-1:0] fout_q, fout_d;
	logic test_q, test_d, out_en;
	assign out_en = oe_s & ctrl_q[`SSDC_CTRL_OUT_GATE] & ~div_clr;

	always_comb begin
		fout_d = {PAIRS{out_if.clk_out & out_en}};
		unique case (ssdc_test_t'(cfg_q.test))
			SSDC_TST_LOW: test_d = 1'b0;
			SSDC_TST_SDATA: test_d = data_s;
			SSDC_TST_FB: test_d = fb_if.clk_out;
			SSDC_TST_FOUT: test_d = out_if.clk_out;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fout_q <= '0;
			test_q <= 1'b0;
		end else begin
			fout_q <= fout_d;
			test_q <= test_d;
		end
	end

	assign fout = fout_q;
	assign fout_n = ~fout_q;
	assign test_out = test_q;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	a_shift_capture: assert property (
		sclk_rise |=> shift_q == ssdc_word_t'({$past(shift_q[13:0]), $past(data_s)}))
		else $error("serial bit not shifted");
	a_load_rise_copy: assert property (load_rise |=> cfg_q == $past(shift_q))
		else $error("word not transferred at load rise");
	a_load_fall_hold: assert property (
		load_fall |=> cfg_q.fb_div == $past(shift_q.fb_div) &&
			cfg_q.out_div == $past(shift_q.out_div))
		else $error("divide values not latched at load fall");
	a_pass_through: assert property (
		load_s && !load_rise && sclk_rise |=> cfg_q.fb_div == $past(shifted.fb_div))
		else $error("pass-through did not reach divider");
	a_test_low: assert property (cfg_q.test == 2'b00 |=> !test_out)
		else $error("monitor not low");
	a_test_data: assert property (cfg_q.test == 2'b01 |=> test_out == $past(data_s))
		else $error("monitor not following serial data");
	a_reset_default: assert property ($rose(rstn) |-> cfg_q == WORD_RESET)
		else $error("power-up settings wrong");
	a_ref_period: assert property (disable iff (!rstn || div_clr)
		$rose(ref_cmp_clk) |-> ref_cmp_clk [*8] ##1 !ref_cmp_clk)
		else $error("reference prescale period wrong");
	a_oe_forces_off: assert property (
		!oe_s |=> fout == '0 && fout_n == '1)
		else $error("outputs active while disabled");
	a_mr_forces_off: assert property (mr_s |=> fout == '0 && !fb_cmp_clk)
		else $error("outputs active in master reset");

	c_load_rise: cover property (load_rise);
	c_pass_through: cover property (load_s && sclk_rise);
	c_monitor_fout: cover property (cfg_q.test == 2'b11 && $rose(test_out));
	c_write_resp: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// ==== tb/ssdc_ctl_model.sv ====
// controller model that drives the three-wire serial programming link
// assumes core_clk paces it and that each level is held for four core cycles
`timescale 1ns/1ps
module ssdc_ctl_model (
	input wire logic core_clk,
	output logic serial_clock,
	output logic serial_data,
	output logic serial_load
);
	// idle state: clock parked low, data released to its pull-up, load low
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b1;
		serial_load = 1'b0;
	end
	// four cycles clear the three-edge synchroniser path with some margin
	task automatic hold();
		repeat (4) @(posedge core_clk);
	endtask
	// data settles before the clock rise and stays until after its fall
	task automatic put_bit(input logic b);
		@(posedge core_clk);
		serial_data <= b;
		hold();
		serial_clock <= 1'b1;
		hold();
		serial_clock <= 1'b0;
		hold();
	endtask
	// test_select_high goes first and spread_enable goes last
	task automatic send_word(input logic [14:0] w);
		for (int i = 14; i >= 0; i--) put_bit(w[i]);
		serial_data <= 1'b1; // the released line goes to its pull-up
	endtask
	task automatic set_load(input logic v);
		@(posedge core_clk);
		serial_load <= v;
		hold();
	endtask
endmodule

// ==== tb/synth_serial_divider_config_tb.sv ====
// self-checking bench of the serial divider configuration block
// assumes the controller model drives the serial pins and the bench drives axi
`timescale 1ns/1ps
`include "ssdc_cfg.svh"
module synth_serial_divider_config_tb;
	logic core_clk, rstn, vco_tick, tick_q, output_enable, master_divider_reset;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic serial_clock, serial_data, serial_load;
	logic ref_cmp_clk, fb_cmp_clk, test_out, spread_enable;
	logic [5:0] fout, fout_n;
	logic [14:0] w;
	ssdc_pkg::ssdc_word_t active_word;
	int fail_count = 0, samples_checked = 0, cycles = 0, seed = 32'h286f;
	int t, o, f, s, n, r, rt;
	logic [14:0] ew;

	ssdc_top uut (.*);
	ssdc_ctl_model ctl (.*);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// random vco edges keep the dividers busy; the cycle ceiling cuts a hang
	always @(posedge core_clk) begin
		vco_tick <= 1'($random(seed));
		tick_q <= vco_tick;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fail_count++;
			end_of_test();
		end
	end

	function automatic logic [14:0] mk(int t, int o, int f, int s);
		return {t[1:0], o[2:0], f[8:0], s[0]};
	endfunction
	function automatic logic pick(int k);
		return k == 0 ? fout[0] : k == 1 ? fb_cmp_clk : ref_cmp_clk;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// write master: both channels offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rp);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk("rdata", e, rd);
		chk("rresp", er, rs);
	endtask
	// two successive half periods, in vco ticks (cycles for the reference)
	// fout sits one flop behind the divider, so its ticks are counted one edge late
	task automatic half(input int k, output int a, output int c);
		logic v;
		int g;
		g = 0;
		#1;
		for (int h = 0; h < 3; h++) begin
			v = pick(k);
			c = 0;
			while (pick(k) === v && g < 3000) begin
				@(posedge core_clk);
				if (k == 2 || (k == 0 ? tick_q : vco_tick)) c++;
				#1;
				g++;
			end
			if (h == 1) a = c;
		end
	endtask
	// edges of the monitor against edges of the clock it should show
	task automatic toggles(input int k, output int a, output int b);
		logic pa, pb;
		a = 0;
		b = 0;
		pa = pick(k);
		pb = test_out;
		repeat (600) begin
			@(posedge core_clk);
			#1;
			if (pick(k) !== pa) a++;
			if (test_out !== pb) b++;
			pa = pick(k);
			pb = test_out;
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		rstn = 1'b0;
		output_enable = 1'b1;
		master_divider_reset = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = 4'h0;
		s_axi_araddr = 4'h0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		repeat (20) @(posedge core_clk);
		chk("fout in reset", 0, fout);
		chk("fout_n in reset", 6'h3f, fout_n);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		ew = mk(1, 1, 192, 0);
		chk("active_word", ew, active_word);
		chk("spread_enable", 0, spread_enable);
		chk("monitor idle", 1, test_out);
		rchk(`SSDC_REG_STATUS, ew, `SSDC_RESP_OKAY);
		rchk(`SSDC_REG_CTRL, `SSDC_CTRL_RESET, `SSDC_RESP_OKAY);
		rchk(4'hc, 0, `SSDC_RESP_SLVERR);
		wr(4'hc, 32'h0000_0001, rs);
		chk("bresp", `SSDC_RESP_SLVERR, rs);
		wr(`SSDC_REG_STATUS, 32'h0000_0000, rs);
		rchk(`SSDC_REG_STATUS, ew, `SSDC_RESP_OKAY);
		half(2, n, r);
		chk("ref half", 8, n);
		chk("ref half", 8, r);
		// every monitor code, output divide codes 0 to 4 and one of 5 to 7; last word silences the monitor
		for (int i = 0; i < 6; i++) begin
			t = i == 5 ? 0 : i % 4;
			o = i < 5 ? i : 5 + ($unsigned($random(seed)) % 3);
			f = 120 + ($unsigned($random(seed)) % 121);
			s = $random(seed) & 1;
			rt = o > 4 ? 16 : 1 << o;
			w = mk(t, o, f, s);
			ctl.send_word(w);
			rchk(`SSDC_REG_SHIFT, w, `SSDC_RESP_OKAY);
			chk("held word", ew, active_word);
			ctl.set_load(1'b1);
			ctl.set_load(1'b0);
			ew = w;
			#1;
			chk("active_word", ew, active_word);
			chk("spread_enable", s, spread_enable);
			half(0, n, r);
			chk("fout high half", rt, n);
			chk("fout low half", rt, r);
			chk("fout_n", 6'h3f ^ fout, fout_n);
			half(1, n, r);
			chk("fb half", f, n);
			chk("fb half", f, r);
			if (t == 0) chk("monitor off", 0, test_out);
			if (t == 1) chk("monitor data", serial_data, test_out);
			if (t >= 2) toggles(t == 2 ? 1 : 0, n, r);
			if (t >= 2) chk("monitor follows", 1, n > 0 && n - r <= 1 && r - n <= 1);
		end
		// pin reset, pin enable, soft reset and soft gate each stop the outputs
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk);
			if (k == 0) master_divider_reset <= 1'b1;
			if (k == 1) output_enable <= 1'b0;
			if (k > 1) wr(`SSDC_REG_CTRL, k == 2 ? 3 : 0, rs);
			repeat (4) @(posedge core_clk);
			repeat (40) begin
				@(posedge core_clk);
				#1;
				chk("fout blocked", 0, fout);
				chk("fout_n blocked", 6'h3f, fout_n);
			end
			if (k > 1) rchk(`SSDC_REG_CTRL, k == 2 ? 3 : 0, `SSDC_RESP_OKAY);
			@(posedge core_clk);
			master_divider_reset <= 1'b0;
			output_enable <= 1'b1;
			if (k > 1) wr(`SSDC_REG_CTRL, `SSDC_CTRL_RESET, rs);
			half(0, n, r);
			chk("fout restart", rt, r);
		end
		// load held high: divide fields follow the shifter, then hold once it falls
		ctl.set_load(1'b1);
		w = mk(3, 0, 130, 1);
		ctl.send_word(w);
		ew = {ew[14:13], w[12:1], ew[0]};
		#1;
		chk("pass through", ew, active_word);
		ctl.set_load(1'b0);
		ctl.send_word(mk(0, 2, 200, 0));
		#1;
		chk("latched", ew, active_word);
		end_of_test();
	end
endmodule
